// ---- core/sat_top.sv ----
// segment address translator: pins, registers, translation sequencing
module sat_top
	import sat_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        sel_n_in,
	input  wire logic        addr_strobe_n_in,
	input  wire logic        upper_strobe_n_in,
	input  wire logic        lower_strobe_n_in,
	input  wire logic        rd_wr_n_in,
	input  wire logic [4:0]  op_select_in,
	input  wire logic [3:0]  cycle_type_code_in,
	input  wire logic [15:0] log_addr_in,
	input  wire logic [15:0] mux_port_in,
	output logic      [15:0] mux_port_out,
	output logic             mux_port_oe_out,
	output logic             data_xcvr_enable_n_out,
	output logic             data_xcvr_enable_oe_out,
	output logic             dtack_n_out,
	output logic             dtack_oe_out,
	output logic             mapped_strobe_n_out,
	output logic             mapped_strobe_oe_out,
	output logic             addr_hold_n_out,
	output logic             addr_hold_oe_out,
	input  wire logic        go_n_in,
	output logic             go_n_out,
	output logic             go_oe_out,
	input  wire logic        fault_n_in,
	output logic             fault_n_out,
	output logic             fault_oe_out,
	input  wire logic        any_n_in,
	output logic             any_n_out,
	output logic             any_oe_out,
	input  wire logic        all_in,
	output logic             all_out,
	output logic             all_oe_out
);
	////////////////////////////////////////////////////////////////////////
	// storage
	logic [7:0]            task_table [SAT_TASKS];
	logic [15:0]           lba [SAT_NUM_DESC];
	logic [15:0]           lam [SAT_NUM_DESC];
	logic [15:0]           pba [SAT_NUM_DESC];
	logic [7:0]            task_number [SAT_NUM_DESC];
	logic [7:0]            task_mask [SAT_NUM_DESC];
	logic [7:0]            ssr [SAT_NUM_DESC];
	logic [SAT_DESC_W-1:0] desc_ptr;
	logic [15:0]           status;
	sat_state_t            state;
	logic [2:0]            fault_cnt;

	////////////////////////////////////////////////////////////////////////
	// synchronised pins
	logic [SAT_SYNC_W-1:0] sync_bus;
	logic                  cs, as, us, ls, rd, go_seen, fault_seen;
	logic                  any_seen, all_seen;
	logic [4:0]            op;
	logic [3:0]            cyc_type;
	logic [15:0]           la;
	logic [15:0]           pin_data;

	sat_sync #(.WIDTH(SAT_SYNC_W)) u_sync (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.pins_in    ({~sel_n_in, ~addr_strobe_n_in, ~upper_strobe_n_in,
			~lower_strobe_n_in, rd_wr_n_in, ~go_n_in, ~fault_n_in,
			~any_n_in, all_in, op_select_in, cycle_type_code_in,
			log_addr_in, mux_port_in}),
		.rst_val_in ({4'h0, 1'b1, 4'h0, 41'h0}),
		.sync_out   (sync_bus)
	);

	assign {cs, as, us, ls, rd, go_seen, fault_seen, any_seen, all_seen,
		op, cyc_type, la, pin_data} = sync_bus;

	////////////////////////////////////////////////////////////////////////
	// translation lookup
	logic                  hit, wp;
	logic [SAT_DESC_W-1:0] hit_index;
	logic [15:0]           phys;
	logic [7:0]            cur_task;

	assign cur_task = task_table[cyc_type];

	sat_match u_match (
		.log_addr_in (la),
		.task_in     (cur_task),
		.lba_in      (lba),
		.lam_in      (lam),
		.pba_in      (pba),
		.task_num_in (task_number),
		.task_msk_in (task_mask),
		.ssr_in      (ssr),
		.hit_out     (hit),
		.wp_out      (wp),
		.index_out   (hit_index),
		.phys_out    (phys)
	);

	// strobe-steered byte merge for register writes
	function automatic logic [15:0] sat_merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic upper, input logic lower);
		sat_merge = {upper ? new_v[15:8] : old_v[15:8],
			lower ? new_v[7:0] : old_v[7:0]};
	endfunction : sat_merge

	////////////////////////////////////////////////////////////////////////
	// operation decode
	logic        acc_start, xl_start, wr_now, violation;
	logic [15:0] rd_word;

	// cycle starts once a strobe is seen, so write data is already valid
	assign acc_start = (state == SAT_IDLE) && cs && (us || ls);
	assign xl_start  = (state == SAT_IDLE) && !cs && as;
	assign wr_now    = acc_start && !rd;
	assign violation = wp && !rd;

	always_comb
	begin
		rd_word = SAT_WORD_RST;
		case (op)
			SAT_OFF_LBA:    rd_word = lba[desc_ptr];
			SAT_OFF_LAM:    rd_word = lam[desc_ptr];
			SAT_OFF_PBA:    rd_word = pba[desc_ptr];
			SAT_OFF_TASK:   rd_word = {task_number[desc_ptr],
				task_mask[desc_ptr]};
			SAT_OFF_SSRPTR: rd_word = {ssr[desc_ptr], 3'h0, desc_ptr};
			SAT_OFF_STATUS: rd_word = status;
			default:
				if (op[4:3] == 2'b00)
					rd_word = {task_table[{op[2:0], 1'b0}],
						task_table[{op[2:0], 1'b1}]};
				else
					rd_word = SAT_WORD_RST;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer
	sat_state_t next_state;

	always_comb
	begin
		next_state = state;
		case (state)
			SAT_IDLE:
				if (acc_start)
					next_state = SAT_ACC;
				else if (xl_start)
					next_state = SAT_XLATE;
			SAT_XLATE:
				if (hit && !violation)
					next_state = SAT_MAPPED;
				else
					next_state = SAT_FAULTED;
			SAT_MAPPED:
				if (!as)
					next_state = SAT_RELEASE;
			SAT_FAULTED:
				if (fault_cnt == 3'h0 && !as)
					next_state = SAT_RELEASE;
			SAT_RELEASE:
				next_state = SAT_IDLE;
			SAT_ACC:
				if (!cs || !(us || ls))
					next_state = SAT_ACC_END;
			SAT_ACC_END:
				next_state = SAT_IDLE;
			default:
				next_state = SAT_IDLE;
		endcase
	end

	// any state is left for idle on reset
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			state <= SAT_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			fault_cnt <= 3'h0;
		else if (state == SAT_XLATE)
			fault_cnt <= SAT_FAULT_CYC - 3'h1;
		else if (fault_cnt != 3'h0)
			fault_cnt <= fault_cnt - 3'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			desc_ptr <= '0;
			for (int i = 0; i < SAT_TASKS; i++)
				task_table[i] <= SAT_TT_RST;
			for (int i = 0; i < SAT_NUM_DESC; i++)
			begin
				lba[i]         <= SAT_WORD_RST;
				lam[i]         <= SAT_WORD_RST;
				pba[i]         <= SAT_WORD_RST;
				task_number[i] <= SAT_TT_RST;
				task_mask[i]   <= SAT_TT_RST;
				ssr[i]         <= SAT_SSR_RST;
			end
		end
		else if (wr_now)
		begin
			case (op)
				SAT_OFF_LBA: lba[desc_ptr] <=
					sat_merge(lba[desc_ptr], pin_data, us, ls);
				SAT_OFF_LAM: lam[desc_ptr] <=
					sat_merge(lam[desc_ptr], pin_data, us, ls);
				SAT_OFF_PBA: pba[desc_ptr] <=
					sat_merge(pba[desc_ptr], pin_data, us, ls);
				SAT_OFF_TASK:
				begin
					if (us)
						task_number[desc_ptr] <= pin_data[15:8];
					if (ls)
						task_mask[desc_ptr] <= pin_data[7:0];
				end
				SAT_OFF_SSRPTR:
				begin
					if (us)
						ssr[desc_ptr] <= pin_data[15:8];
					if (ls)
						desc_ptr <= pin_data[SAT_DESC_W-1:0];
				end
				default:
					if (op[4:3] == 2'b00)
					begin
						if (us)
							task_table[{op[2:0], 1'b0}] <= pin_data[15:8];
						if (ls)
							task_table[{op[2:0], 1'b1}] <= pin_data[7:0];
					end
			endcase
		end
	end

	// sticky status, all and any bits follow their lines each clock: a new event wins over a clearing write
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			status <= SAT_WORD_RST;
		else
		begin
			if (wr_now && op == SAT_OFF_STATUS)
				status <= status & ~sat_merge(16'h0000, pin_data, us, ls);
			if (state == SAT_XLATE)
			begin
				status[SAT_ST_HIT]   <= hit;
				status[SAT_ST_WV]    <= hit && violation;
				status[SAT_ST_UNDEF] <= !hit;
				status[SAT_DESC_W-1:0] <= hit_index;
			end
			if (fault_seen)
				status[SAT_ST_EXTF] <= 1'b1;
			status[SAT_ST_ALL] <= all_seen;
			status[SAT_ST_ANY] <= any_seen;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// port and bus handshake lines; a released handshake line is driven inactive
	// for one clock before its enable drops
	logic next_port_oe, next_ack, next_map, next_hold, next_go;
	logic global_op, slave_op;

	assign global_op    = cs && op == SAT_OFF_GLOBAL;
	assign slave_op     = go_seen && !cs;
	assign next_ack     = next_state == SAT_ACC && cs;
	assign next_map     = next_state == SAT_MAPPED;
	assign next_hold    = next_map || state == SAT_MAPPED;
	assign next_go      = next_ack && global_op;
	// one direction at a time: driven only for reads or physical bits
	assign next_port_oe = (next_ack && rd) || next_map;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			mux_port_out    <= SAT_WORD_RST;
			mux_port_oe_out <= 1'b0;
		end
		else
		begin
			mux_port_oe_out <= next_port_oe;
			if (state == SAT_XLATE)
				mux_port_out <= phys;
			else if (acc_start)
				mux_port_out <= rd_word;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			dtack_n_out             <= 1'b1;
			dtack_oe_out            <= 1'b0;
			data_xcvr_enable_n_out  <= 1'b1;
			data_xcvr_enable_oe_out <= 1'b0;
		end
		else
		begin
			dtack_n_out             <= !next_ack;
			dtack_oe_out            <= next_ack || !dtack_n_out;
			data_xcvr_enable_n_out  <= !next_ack;
			data_xcvr_enable_oe_out <= next_ack
				|| !data_xcvr_enable_n_out;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			mapped_strobe_n_out  <= 1'b1;
			mapped_strobe_oe_out <= 1'b0;
			addr_hold_n_out      <= 1'b1;
			addr_hold_oe_out     <= 1'b0;
		end
		else
		begin
			mapped_strobe_n_out  <= !next_map;
			mapped_strobe_oe_out <= next_map
				|| !mapped_strobe_n_out;
			addr_hold_n_out      <= !next_hold;
			addr_hold_oe_out     <= next_hold || !addr_hold_n_out;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			go_n_out  <= 1'b1;
			go_oe_out <= 1'b0;
		end
		else
		begin
			go_n_out  <= !next_go;
			go_oe_out <= next_go || !go_n_out;
		end
	end

	// open-drain lines: only a low is ever driven
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			fault_n_out  <= 1'b0;
			fault_oe_out <= 1'b0;
			any_n_out    <= 1'b0;
			any_oe_out   <= 1'b0;
			all_out      <= 1'b0;
			all_oe_out   <= 1'b0;
		end
		else
		begin
			fault_n_out  <= 1'b0;
			fault_oe_out <= next_state == SAT_FAULTED;
			any_n_out    <= 1'b0;
			any_oe_out   <= slave_op && status[SAT_ST_HIT];
			// a slave without the event holds the wire-AND low
			all_out      <= 1'b0;
			all_oe_out   <= slave_op && !status[SAT_ST_HIT];
		end
	end
endmodule : sat_top

// ---- shared/sat_pkg.sv ----
// constants and types shared by the segment address translator
//
// Summary of operation
// - one 8-bit task number per cycle type
// - descriptor holds six registers, nine bytes
// - segment sizes powers of two, 256B-16MB
// - segment starts aligned to segment size
// - translate logical bits 8-23 to physical
// - fault, any lines active-low wire-OR
// - all line active-high wire-AND
// - go, mapped strobe tri-state, one driver
// - drive inactive before releasing tri-state
// - port pin is input or output, never both
// - select plus global address makes us master
// - op select decodes operation and register
// - read/write checks protection, sets direction
// - reset works from any state, 16 clocks
// - acknowledge read data valid, write accepted
// - acknowledge only while selected, rescindable
// - upper strobe even byte, lower odd byte
// - address strobe starts translation phase
// - port carries data or physical upper bits
// - cycle type indexes the task table
// - fault five clocks or until strobe negates
// - mapped strobe on descriptor match
// - address hold released after mapped strobe
package sat_pkg;
	localparam int         SAT_NUM_DESC   = 32;
	localparam int         SAT_DESC_W     = 5;
	localparam int         SAT_TASKS      = 16;
	localparam int         SAT_SYNC_W     = 50;
	// register map on op_select, one 16-bit word per code
	localparam logic [4:0] SAT_OFF_TT     = 5'h00;
	localparam logic [4:0] SAT_OFF_LBA    = 5'h08;
	localparam logic [4:0] SAT_OFF_LAM    = 5'h09;
	localparam logic [4:0] SAT_OFF_PBA    = 5'h0a;
	localparam logic [4:0] SAT_OFF_TASK   = 5'h0b;
	localparam logic [4:0] SAT_OFF_SSRPTR = 5'h0c;
	localparam logic [4:0] SAT_OFF_STATUS = 5'h0d;
	localparam logic [4:0] SAT_OFF_GLOBAL = 5'h1f;
	// segment status field positions
	localparam int         SAT_SSR_EN     = 0;
	localparam int         SAT_SSR_WP     = 1;
	// status word field positions
	localparam int         SAT_ST_HIT     = 15;
	localparam int         SAT_ST_WV      = 14;
	localparam int         SAT_ST_UNDEF   = 13;
	localparam int         SAT_ST_EXTF    = 12;
	localparam int         SAT_ST_ALL     = 11;
	localparam int         SAT_ST_ANY     = 10;
	// reset values
	localparam logic [7:0]  SAT_TT_RST    = 8'h00;
	localparam logic [7:0]  SAT_SSR_RST   = 8'h00;
	localparam logic [15:0] SAT_WORD_RST  = 16'h0000;
	// timing counts in clocks
	localparam logic [2:0] SAT_FAULT_CYC  = 3'h5;
	localparam int         SAT_RST_MIN_CYC = 16;

	typedef enum logic [2:0] {
		SAT_IDLE    = 3'b000,
		SAT_XLATE   = 3'b001,
		SAT_MAPPED  = 3'b011,
		SAT_RELEASE = 3'b010,
		SAT_FAULTED = 3'b110,
		SAT_ACC     = 3'b100,
		SAT_ACC_END = 3'b101
	} sat_state_t;
endpackage : sat_pkg

// ---- core/sat_sync.sv ----
// pin synchroniser: three flops, change accepted when last two agree
module sat_sync
	import sat_pkg::*;
#(
	parameter int WIDTH = SAT_SYNC_W
)(
	input  wire logic             clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic [WIDTH-1:0] pins_in,
	input  wire logic [WIDTH-1:0] rst_val_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	// reset value is a tied constant at the instance, not a live signal
	always_ff @(posedge clk_in)
	begin
		s1 <= pins_in;
		s2 <= s1;
		s3 <= s2;
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			sync_out <= rst_val_in;
		else
			for (int i = 0; i < WIDTH; i++)
				if (s2[i] == s3[i])
					sync_out[i] <= s3[i];
	end
endmodule : sat_sync

// ---- core/sat_match.sv ----
// combinational descriptor match and physical merge
module sat_match
	import sat_pkg::*;
(
	input  wire logic [15:0]           log_addr_in,
	input  wire logic [7:0]            task_in,
	input  wire logic [15:0]           lba_in [SAT_NUM_DESC],
	input  wire logic [15:0]           lam_in [SAT_NUM_DESC],
	input  wire logic [15:0]           pba_in [SAT_NUM_DESC],
	input  wire logic [7:0]            task_num_in [SAT_NUM_DESC],
	input  wire logic [7:0]            task_msk_in [SAT_NUM_DESC],
	input  wire logic [7:0]            ssr_in [SAT_NUM_DESC],
	output logic                       hit_out,
	output logic                       wp_out,
	output logic [SAT_DESC_W-1:0]      index_out,
	output logic [15:0]                phys_out
);
	// lowest index wins when segments overlap
	always_comb
	begin
		hit_out   = 1'b0;
		wp_out    = 1'b0;
		index_out = '0;
		phys_out  = log_addr_in;
		for (int i = SAT_NUM_DESC - 1; i >= 0; i--)
		begin
			if (ssr_in[i][SAT_SSR_EN]
				&& (((log_addr_in ^ lba_in[i]) & lam_in[i]) == 16'h0000)
				&& (((task_in ^ task_num_in[i]) & task_msk_in[i])
					== 8'h00))
			begin
				hit_out   = 1'b1;
				wp_out    = ssr_in[i][SAT_SSR_WP];
				index_out = SAT_DESC_W'(i);
				// masked bits come from the base, so both starts align
				phys_out  = (pba_in[i] & lam_in[i])
					| (log_addr_in & ~lam_in[i]);
			end
		end
	end
endmodule : sat_match

// ---- sim/sat_chk.sv ----
// concurrent checks on the translator's pins, bound to the top module
module sat_chk (
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	input  wire logic sel_n_in,
	input  wire logic addr_strobe_n_in,
	input  wire logic dtack_n_out,
	input  wire logic dtack_oe_out,
	input  wire logic mapped_strobe_n_out,
	input  wire logic mapped_strobe_oe_out,
	input  wire logic addr_hold_n_out,
	input  wire logic addr_hold_oe_out,
	input  wire logic mux_port_oe_out,
	input  wire logic fault_n_out,
	input  wire logic fault_oe_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dcb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	////////////////////////////////////////////////////////////////////////
	ack_when_sel_a: assert property ($fell(dtack_n_out) |-> !sel_n_in)
		else $error("acknowledge asserted without select");
	// pin synchronisers add up to four clocks before the take
	ack_latency_a: assert property ($fell(sel_n_in)
		|-> ##[2:10] (!dtack_n_out && dtack_oe_out))
		else $error("acknowledge late after select");
	ack_rescind_a: assert property ($rose(dtack_n_out)
		|-> dtack_oe_out ##1 !dtack_oe_out)
		else $error("acknowledge not negated before float");
	strobe_rescind_a: assert property ($rose(mapped_strobe_n_out)
		|-> mapped_strobe_oe_out ##1 !mapped_strobe_oe_out)
		else $error("mapped strobe not negated before float");
	hold_order_a: assert property ($rose(addr_hold_n_out)
		|-> $past(mapped_strobe_n_out) && addr_hold_oe_out
		##1 !addr_hold_oe_out)
		else $error("address hold released out of order");
	map_drive_a: assert property ((!mapped_strobe_n_out &&
		mapped_strobe_oe_out) |-> (!addr_hold_n_out && mux_port_oe_out))
		else $error("mapped strobe without hold or port drive");
	xlate_start_a: assert property (($fell(addr_strobe_n_in) &&
		sel_n_in) |-> ##[2:10] (!mapped_strobe_n_out || fault_oe_out))
		else $error("no translation result after address strobe");
	fault_len_a: assert property ($rose(fault_oe_out)
		|-> (fault_oe_out && !fault_n_out) [*5])
		else $error("fault shorter than five clocks");
	fault_no_map_a: assert property (fault_oe_out
		|-> !(mapped_strobe_oe_out && !mapped_strobe_n_out))
		else $error("fault and mapped strobe together");
endmodule : sat_chk

bind sat_top sat_chk i_chk (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sel_n_in(sel_n_in),
	.addr_strobe_n_in(addr_strobe_n_in), .dtack_n_out(dtack_n_out),
	.dtack_oe_out(dtack_oe_out), .mapped_strobe_n_out(mapped_strobe_n_out),
	.mapped_strobe_oe_out(mapped_strobe_oe_out),
	.addr_hold_n_out(addr_hold_n_out), .addr_hold_oe_out(addr_hold_oe_out),
	.mux_port_oe_out(mux_port_oe_out), .fault_n_out(fault_n_out),
	.fault_oe_out(fault_oe_out)
);

// ---- sim/sat_bus_model.sv ----
// far side: resolves the shared lines and the port as the board wires them
module sat_bus_model (
	input  wire logic        [15:0] port_out_in,
	input  wire logic               port_oe_in,
	input  wire logic        [15:0] cpu_data_in,
	input  wire logic               map_n_in,
	input  wire logic               map_oe_in,
	input  wire logic               go_n_in,
	input  wire logic               go_oe_in,
	input  wire logic               peer_go_n_in,
	input  wire logic               fault_oe_in,
	input  wire logic               any_oe_in,
	input  wire logic               all_oe_in,
	input  wire logic        [8:0]  cpu_low_in,
	output logic             [15:0] port_lvl_out,
	output logic                    map_lvl_out,
	output logic                    go_lvl_out,
	output logic                    fault_lvl_out,
	output logic                    any_lvl_out,
	output logic                    all_lvl_out,
	output logic             [8:0]  phys_low_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// the bench inverts its data after each access, so a stale bus shows
	assign port_lvl_out  = port_oe_in ? port_out_in : cpu_data_in;
	assign map_lvl_out   = map_oe_in ? map_n_in : 1'b1;
	// a peer unit may master a global operation while this one floats
	assign go_lvl_out    = (go_oe_in ? go_n_in : 1'b1)
		& peer_go_n_in;
	// low address bits and byte strobes go straight to memory
	assign phys_low_out  = cpu_low_in;
	assign fault_lvl_out = ~fault_oe_in;
	assign any_lvl_out   = ~any_oe_in;
	assign all_lvl_out   = ~all_oe_in;
endmodule : sat_bus_model

// ---- sim/sat_tb_top.sv ----
// self-checking bench for the segment address translator
module sat_tb_top
	import sat_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, sel_n, as_n, uds_n, lds_n, rw, g;
	logic [4:0]  ops;
	logic [3:0]  ct;
	logic [15:0] la, pdata, q, port_o, port_l;
	logic        port_oe, dt_n, dt_oe, mst_n, mst_oe, hld_n, hld_oe;
	logic        go_o, go_oe, flt_oe, any_oe, all_oe, xe_n, xe_oe;
	logic        mst_l, go_l, flt_l, any_l, all_l, peer_go_n;
	logic        flt_o, any_o, all_o;
	logic [8:0]  lo;
	int          err_count, n_tests, cyc;

	sat_top i_dut (
		.clk_in(clk), .sys_rst_in(rst), .sel_n_in(sel_n),
		.addr_strobe_n_in(as_n), .upper_strobe_n_in(uds_n),
		.lower_strobe_n_in(lds_n), .rd_wr_n_in(rw), .op_select_in(ops),
		.cycle_type_code_in(ct), .log_addr_in(la), .mux_port_in(port_l),
		.mux_port_out(port_o), .mux_port_oe_out(port_oe),
		.data_xcvr_enable_n_out(xe_n), .data_xcvr_enable_oe_out(xe_oe),
		.dtack_n_out(dt_n), .dtack_oe_out(dt_oe),
		.mapped_strobe_n_out(mst_n), .mapped_strobe_oe_out(mst_oe),
		.addr_hold_n_out(hld_n), .addr_hold_oe_out(hld_oe),
		.go_n_in(go_l), .go_n_out(go_o), .go_oe_out(go_oe),
		.fault_n_in(flt_l), .fault_n_out(flt_o), .fault_oe_out(flt_oe),
		.any_n_in(any_l), .any_n_out(any_o), .any_oe_out(any_oe),
		.all_in(all_l), .all_out(all_o), .all_oe_out(all_oe)
	);

	sat_bus_model i_far (
		.port_out_in(port_o), .port_oe_in(port_oe), .cpu_data_in(pdata),
		.map_n_in(mst_n), .map_oe_in(mst_oe), .go_n_in(go_o),
		.go_oe_in(go_oe), .peer_go_n_in(peer_go_n),
		.fault_oe_in(flt_oe), .any_oe_in(any_oe), .all_oe_in(all_oe),
		.cpu_low_in({7'h55, uds_n, lds_n}), .port_lvl_out(port_l),
		.map_lvl_out(mst_l), .go_lvl_out(go_l), .fault_lvl_out(flt_l),
		.any_lvl_out(any_l), .all_lvl_out(all_l), .phys_low_out(lo)
	);

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic give_verdict();
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [15:0] e, g_v);
		n_tests++;
		if (g_v !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g_v);
		end
	endtask : chk

	// one processor access; strobes and data go up together
	task automatic reg_acc(input logic [4:0] op, input logic [1:0] bs,
		input logic wr, input logic [15:0] d);
		int n;
		@(posedge clk);
		sel_n <= 1'b0;
		ops   <= op;
		rw    <= ~wr;
		pdata <= d;
		uds_n <= ~bs[1];
		lds_n <= ~bs[0];
		for (n = 0; n < 30 && dt_n !== 1'b0; n++) @(negedge clk);
		chk("ack", 16'h0000, 16'(dt_n));
		chk("port dir", 16'(!wr), 16'(port_oe));
		chk("xcvr", 16'h0000, 16'(xe_n));
		q = port_l;
		g = go_l;
		@(posedge clk);
		sel_n <= 1'b1;
		uds_n <= 1'b1;
		lds_n <= 1'b1;
		pdata <= ~d;
		for (n = 0; n < 30 && dt_oe !== 1'b0; n++) @(negedge clk);
		repeat (2) @(posedge clk);
	endtask : reg_acc

	// one translated cycle, address strobe held past the fault minimum
	task automatic xlate(input logic [15:0] a, input logic [3:0] c,
		input logic wr, input logic f, input logic [15:0] p);
		int n;
		@(posedge clk);
		la   <= a;
		ct   <= c;
		rw   <= ~wr;
		as_n <= 1'b0;
		for (n = 0; n < 30 && mst_l !== 1'b0 && flt_l !== 1'b0; n++)
			@(negedge clk);
		chk("fault", 16'(f), 16'(!flt_l));
		chk("mapped", 16'(!f), 16'(!mst_l));
		chk("low bits", 16'h0157, 16'(lo));
		if (!f)
			chk("phys", p, port_l);
		repeat (8) @(negedge clk);
		chk("stand", 16'h0000, 16'(f ? flt_l : mst_l));
		@(posedge clk);
		as_n <= 1'b1;
		la   <= ~a;
		for (n = 0; n < 30 && (hld_oe | flt_oe | mst_oe) !== 1'b0; n++)
			@(negedge clk);
		chk("release", 16'h0000, 16'({hld_oe, flt_oe, mst_oe}));
		repeat (2) @(posedge clk);
	endtask : xlate

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("idle oe", 16'h0000, 16'({port_oe, dt_oe, mst_oe, hld_oe,
			flt_oe, go_oe, any_oe, all_oe, xe_oe, flt_o, any_o,
			all_o}));
		chk("idle n", 16'h001f,
			16'({dt_n, mst_n, hld_n, xe_n, go_o}));
	endtask : t_reset

	task automatic t_table();
		reg_acc(SAT_OFF_TT + 5'h02, 2'b01, 1'b1, 16'h0007);
		reg_acc(SAT_OFF_TT + 5'h02, 2'b10, 1'b1, 16'h5aff);
		reg_acc(SAT_OFF_TT + 5'h02, 2'b11, 1'b0, 16'h0000);
		chk("table", 16'h5a07, q);
		reg_acc(5'h1e, 2'b11, 1'b1, 16'hffff);
		reg_acc(5'h1e, 2'b11, 1'b0, 16'h0000);
		chk("unmapped", 16'h0000, q);
	endtask : t_table

	task automatic t_desc();
		reg_acc(SAT_OFF_SSRPTR, 2'b01, 1'b1, 16'h0000);
		reg_acc(SAT_OFF_SSRPTR, 2'b10, 1'b1, 16'h0300);
		reg_acc(SAT_OFF_LBA, 2'b11, 1'b1, 16'h1200);
		reg_acc(SAT_OFF_LAM, 2'b11, 1'b1, 16'hff00);
		reg_acc(SAT_OFF_PBA, 2'b11, 1'b1, 16'h3400);
		reg_acc(SAT_OFF_TASK, 2'b11, 1'b1, 16'h07ff);
		reg_acc(SAT_OFF_PBA, 2'b11, 1'b0, 16'h0000);
		chk("phys base", 16'h3400, q);
	endtask : t_desc

	task automatic t_xlate();
		xlate(16'h12ab, 4'h5, 1'b0, 1'b0, 16'h34ab);
		xlate(16'h12ff, 4'h5, 1'b0, 1'b0, 16'h34ff);
		xlate(16'h12ab, 4'h5, 1'b1, 1'b1, 16'h0000);
		xlate(16'h12ab, 4'h4, 1'b0, 1'b1, 16'h0000);
		xlate(16'h1300, 4'h5, 1'b0, 1'b1, 16'h0000);
	endtask : t_xlate

	task automatic t_global();
		reg_acc(SAT_OFF_GLOBAL, 2'b11, 1'b1, 16'h0000);
		chk("go", 16'h0000, 16'(g));
	endtask : t_global

	// last translation was undefined: undefined, fault seen, all high
	task automatic t_status();
		reg_acc(SAT_OFF_STATUS, 2'b11, 1'b0, 16'h0000);
		chk("status", 16'h3800, q);
		reg_acc(SAT_OFF_STATUS, 2'b11, 1'b1, 16'hffff);
		reg_acc(SAT_OFF_STATUS, 2'b11, 1'b0, 16'h0000);
		chk("status clr", 16'h0800, q);
	endtask : t_status

	// a peer masters a global operation; this unit reports its last hit
	task automatic t_slave();
		xlate(16'h12ab, 4'h5, 1'b0, 1'b0, 16'h34ab);
		@(posedge clk);
		peer_go_n <= 1'b0;
		repeat (7) @(negedge clk);
		chk("any", 16'h0001, 16'(any_oe));
		chk("any line", 16'h0000, 16'(any_l));
		chk("all", 16'h0000, 16'(all_oe));
		@(posedge clk);
		peer_go_n <= 1'b1;
		repeat (7) @(negedge clk);
		chk("slave end", 16'h0000, 16'({any_oe, all_oe}));
	endtask : t_slave

	// reset while a translation stands mapped
	task automatic t_mid_reset();
		@(posedge clk);
		la   <= 16'h12ab;
		ct   <= 4'h5;
		as_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		as_n <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset();
		reg_acc(SAT_OFF_PBA, 2'b11, 1'b0, 16'h0000);
		chk("reset base", 16'h0000, q);
	endtask : t_mid_reset

	initial
	begin
		rst   = 1'b1;
		sel_n = 1'b1;
		as_n  = 1'b1;
		uds_n = 1'b1;
		lds_n = 1'b1;
		rw    = 1'b1;
		ops   = 5'h00;
		ct    = 4'h0;
		la    = 16'h0000;
		pdata = 16'ha5a5;
		peer_go_n = 1'b1;
		// power-up hold shortened to the minimum count to keep runs short
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset();
		t_table();
		t_desc();
		t_xlate();
		t_status();
		t_global();
		t_slave();
		t_mid_reset();
		give_verdict();
	end

	// a hang ends the run well after the expected few hundred clocks
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			err_count++;
			give_verdict();
		end
	end
endmodule : sat_tb_top
